/* File: rtl/udpc_defs.svh */
// Register offsets, field positions, reset values and timing counts of the pulse counter
`ifndef UDPC_DEFS_SVH
`define UDPC_DEFS_SVH

// Register byte offsets
`define UDPC_CTRL_OFS 12'h000
`define UDPC_PRESET_OFS 12'h004
`define UDPC_COUNT_OFS 12'h008
`define UDPC_COMP_A_OFS 12'h00c
`define UDPC_COMP_B_OFS 12'h010
`define UDPC_EVCFG_OFS 12'h014
`define UDPC_STATUS_OFS 12'h018
`define UDPC_MASK_OFS 12'h01c
`define UDPC_PINS_OFS 12'h020

// Control fields
`define UDPC_CTRL_EN_BIT 0
`define UDPC_CTRL_LOAD_BIT 1
`define UDPC_CTRL_INC_LO 4
`define UDPC_CTRL_DEC_LO 6

// Event configuration: bit n set makes event n load the preset
`define UDPC_EV_A_UP 0
`define UDPC_EV_A_DN 1
`define UDPC_EV_B_UP 2
`define UDPC_EV_B_DN 3
`define UDPC_EV_LOAD 4
`define UDPC_EV_NUM 5

// Reset values
`define UDPC_CTRL_RST 32'h0000_0000
`define UDPC_PRESET_RST 32'h0000_0000
`define UDPC_COMP_RST 32'h0000_0000

// Timing
`define UDPC_CLK_HZ 25000000
`define UDPC_MAX_PULSE_HZ 10000
`define UDPC_MIN_PULSE_CYC (`UDPC_CLK_HZ / `UDPC_MAX_PULSE_HZ)

`endif

/* File: rtl/udpc_pkg.sv */
// Types shared by the pulse counter files
`default_nettype none
package udpc_pkg;
	// Edge selection for one pulse input
	typedef enum logic [1:0] {
		UDPC_EDGE_OFF = 2'h0,
		UDPC_EDGE_RISE = 2'h1,
		UDPC_EDGE_FALL = 2'h2
	} udpc_edge_e;

	// Pins of the pulse side
	typedef struct packed {
		logic increment_pulse_input;
		logic decrement_pulse_input;
		logic direction_input;
		logic hardware_gate_input;
	} udpc_pins_s;
endpackage : udpc_pkg
`default_nettype wire

/* File: rtl/udpc_edge.sv */
// Synchroniser and selectable edge detector for one pulse pin
`default_nettype none
module udpc_edge (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pin and selection
	input wire logic pin,
	input wire logic [1:0] sel,
	// Result
	output logic level,
	output logic pulse
);
	import udpc_pkg::*;

	logic meta_q;
	logic sync_q;
	logic prev_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;

	always_comb begin
		unique case (udpc_edge_e'(sel))
			UDPC_EDGE_RISE: pulse = sync_q & ~prev_q;
			UDPC_EDGE_FALL: pulse = ~sync_q & prev_q;
			default: pulse = 1'b0;
		endcase
	end
endmodule : udpc_edge
`default_nettype wire

/* File: rtl/udpc_top.sv */
// Up/down pulse counter with APB registers, preset load and compare events
`include "udpc_defs.svh"
`default_nettype none

module udpc_top #(
	parameter int CNT_W = 32
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pulse side pins
	input wire udpc_pkg::udpc_pins_s pins,
	// Interrupt
	output logic irq
);
	import udpc_pkg::*;

	logic [31:0] ctrl_q;
	logic [CNT_W-1:0] preset_q;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic [CNT_W-1:0] comp_a_q;
	logic [CNT_W-1:0] comp_b_q;
	logic [`UDPC_EV_NUM-1:0] evcfg_q;
	logic [`UDPC_EV_NUM-1:0] status_q;
	logic [`UDPC_EV_NUM-1:0] mask_q;
	logic load_prev_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge selection

	logic inc_pulse;
	logic dec_pulse;
	logic dir_lvl;
	logic gate_lvl;
	logic inc_lvl;
	logic dec_lvl;

	// Sampling at 25 MHz leaves thousands of cycles per 10 kHz pulse
	udpc_edge u_inc (
		.pclk(pclk),
		.presetn(presetn),
		.pin(pins.increment_pulse_input),
		.sel(ctrl_q[`UDPC_CTRL_INC_LO +: 2]),
		.level(inc_lvl),
		.pulse(inc_pulse)
	);
	udpc_edge u_dec (
		.pclk(pclk),
		.presetn(presetn),
		.pin(pins.decrement_pulse_input),
		.sel(ctrl_q[`UDPC_CTRL_DEC_LO +: 2]),
		.level(dec_lvl),
		.pulse(dec_pulse)
	);
	udpc_edge u_dir (
		.pclk(pclk),
		.presetn(presetn),
		.pin(pins.direction_input),
		.sel(2'h0),
		.level(dir_lvl),
		.pulse()
	);
	udpc_edge u_gate (
		.pclk(pclk),
		.presetn(presetn),
		.pin(pins.hardware_gate_input),
		.sel(2'h0),
		.level(gate_lvl),
		.pulse()
	);

	////////////////////////////////////////////////////////////////////////
	// Counting

	logic run;
	logic step_up;
	logic step_dn;
	logic load_edge;
	logic [`UDPC_EV_NUM-1:0] ev;

	assign run = gate_lvl & ctrl_q[`UDPC_CTRL_EN_BIT];

	always_comb begin
		step_up = 1'b0;
		step_dn = 1'b0;
		if (run && (inc_pulse != dec_pulse)) begin
			if (dir_lvl) begin
				step_up = inc_pulse;
				step_dn = dec_pulse;
			end else begin
				step_up = dec_pulse;
				step_dn = inc_pulse;
			end
		end
	end

	assign load_edge = ctrl_q[`UDPC_CTRL_LOAD_BIT] & ~load_prev_q;

	// Compare events seen on the step about to be taken
	always_comb begin
		ev = '0;
		ev[`UDPC_EV_A_UP] = step_up && (count_q == comp_a_q - CNT_W'(1));
		ev[`UDPC_EV_A_DN] = step_dn && (count_q == comp_a_q);
		ev[`UDPC_EV_B_UP] = step_up && (count_q == comp_b_q - CNT_W'(1));
		ev[`UDPC_EV_B_DN] = step_dn && (count_q == comp_b_q);
		ev[`UDPC_EV_LOAD] = load_edge;
	end

	always_comb begin
		count_d = count_q;
		if (step_up)
			count_d = count_q + CNT_W'(1);
		else if (step_dn)
			count_d = count_q - CNT_W'(1);
		// Event load overrides the step that caused it
		if (|(ev & evcfg_q))
			count_d = preset_q;
		if (load_edge)
			count_d = preset_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			count_q <= '0;
		else
			count_q <= count_d;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			load_prev_q <= 1'b0;
		else
			load_prev_q <= ctrl_q[`UDPC_CTRL_LOAD_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states

	logic setup;
	logic wr;
	logic rd;
	logic hit_ctrl;
	logic hit_preset;
	logic hit_count;
	logic hit_comp_a;
	logic hit_comp_b;
	logic hit_evcfg;
	logic hit_status;
	logic hit_mask;
	logic hit_pins;
	logic hit_any;
	logic [31:0] rdata_d;

	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign rd = setup & ~pwrite;

	// Full 12-bit compare: misaligned and aliased addresses answer with an error
	assign hit_ctrl = (paddr == `UDPC_CTRL_OFS);
	assign hit_preset = (paddr == `UDPC_PRESET_OFS);
	assign hit_count = (paddr == `UDPC_COUNT_OFS);
	assign hit_comp_a = (paddr == `UDPC_COMP_A_OFS);
	assign hit_comp_b = (paddr == `UDPC_COMP_B_OFS);
	assign hit_evcfg = (paddr == `UDPC_EVCFG_OFS);
	assign hit_status = (paddr == `UDPC_STATUS_OFS);
	assign hit_mask = (paddr == `UDPC_MASK_OFS);
	assign hit_pins = (paddr == `UDPC_PINS_OFS);
	assign hit_any = hit_ctrl | hit_preset | hit_count | hit_comp_a | hit_comp_b | hit_evcfg | hit_status |
		hit_mask | hit_pins;

	// Only the enable, load strobe and edge-select bits are kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_q <= `UDPC_CTRL_RST;
		else if (wr && hit_ctrl)
			ctrl_q <= pwdata & 32'h0000_00f3;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			preset_q <= CNT_W'(`UDPC_PRESET_RST);
		else if (wr && hit_preset)
			preset_q <= pwdata[CNT_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			comp_a_q <= CNT_W'(`UDPC_COMP_RST);
		else if (wr && hit_comp_a)
			comp_a_q <= pwdata[CNT_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			comp_b_q <= CNT_W'(`UDPC_COMP_RST);
		else if (wr && hit_comp_b)
			comp_b_q <= pwdata[CNT_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			evcfg_q <= '0;
		else if (wr && hit_evcfg)
			evcfg_q <= pwdata[`UDPC_EV_NUM-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask_q <= '0;
		else if (wr && hit_mask)
			mask_q <= pwdata[`UDPC_EV_NUM-1:0];
	end

	// Sticky events; a new event wins over a write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status_q <= '0;
		else if (wr && hit_status)
			status_q <= (status_q & ~pwdata[`UDPC_EV_NUM-1:0]) | ev;
		else
			status_q <= status_q | ev;
	end

	// Registered, so the interrupt trails the status bit by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_q <= 1'b0;
		else
			irq_q <= |(status_q & mask_q);
	end

	// COUNT and PINS are read-only: writes to them are accepted and dropped
	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (paddr)
			`UDPC_CTRL_OFS: rdata_d = ctrl_q;
			`UDPC_PRESET_OFS: rdata_d = 32'(preset_q);
			`UDPC_COUNT_OFS: rdata_d = 32'(count_q);
			`UDPC_COMP_A_OFS: rdata_d = 32'(comp_a_q);
			`UDPC_COMP_B_OFS: rdata_d = 32'(comp_b_q);
			`UDPC_EVCFG_OFS: rdata_d = 32'(evcfg_q);
			`UDPC_STATUS_OFS: rdata_d = 32'(status_q);
			`UDPC_MASK_OFS: rdata_d = 32'(mask_q);
			`UDPC_PINS_OFS: rdata_d = {28'h000_0000, gate_lvl, dir_lvl, dec_lvl, inc_lvl};
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// Read data captured in the setup cycle; it stands only in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_q <= '0;
		else if (rd && hit_any)
			prdata_q <= rdata_d;
		else
			prdata_q <= '0;
	end

	// The error flag is rebuilt every cycle so it never outlives its access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pslverr_q <= 1'b0;
		else
			pslverr_q <= setup & ~hit_any;
	end

	// Every access is answered in its first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready_q <= 1'b0;
		else
			pready_q <= setup;
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
endmodule : udpc_top
`default_nettype wire

/* File: tb/udpc_monitor.sv */
// Bus and interrupt checker for the pulse counter
`default_nettype none
module udpc_monitor (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and interrupt
	input wire udpc_pkg::udpc_pins_s pins,
	input wire logic irq
);
	import udpc_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////
	AST_READY_NEXT: assert property (psel && !penable |=> pready) else $error("no ready");
	AST_READY_ONE: assert property (pready |=> !pready) else $error("ready too long");
	AST_READY_CAUSE: assert property (pready |-> psel && penable) else $error("stray ready");
	AST_ERR_READY: assert property (pslverr |-> pready) else $error("stray error");
	AST_ERR_MAP: assert property (psel && !penable |=> pslverr == (paddr > 12'h020 || paddr[1:0] != 2'h0))
		else $error("bad error");
	AST_ERR_DATA: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("data on error");
	AST_IRQ_MASKED: assert property (pready && pwrite && paddr == 12'h01c && pwdata == 32'h0 |=> ##1 !irq)
		else $error("irq while masked");
	// Six stable cycles cover the two sync flops and the read register
	AST_PINS: assert property ($stable(pins)[*6] ##0 (pready && !pwrite && paddr == 12'h020) |-> prdata ==
		{28'h0, pins.hardware_gate_input, pins.direction_input, pins.decrement_pulse_input,
		pins.increment_pulse_input}) else $error("pin levels");
	COV_WRITE: cover property (pready && pwrite);
	COV_ERR: cover property (pslverr);
	COV_IRQ: cover property ($rose(irq));
endmodule : udpc_monitor
bind udpc_top udpc_monitor u_mon (.*);
`default_nettype wire

/* File: tb/udpc_src.sv */
// Pulse source model driving the counter's pulse side pins
`default_nettype none
module udpc_src (
	// Clock
	input wire logic pclk,
	// Pins
	output var udpc_pkg::udpc_pins_s pins
);
	import udpc_pkg::*;
	// Half of a 10 kHz period at 25 MHz
	localparam int HALF = 1250;
	initial pins = '0;
	task automatic step(input logic inc, input logic dec, input logic dir, input logic gate);
		@(posedge pclk);
		pins <= {inc, dec, dir, gate};
		repeat (HALF) @(posedge pclk);
	endtask : step
endmodule : udpc_src
`default_nettype wire

/* File: tb/test_up_down_pulse_counter.sv */
// Self-checking bench for the up/down pulse counter
`default_nettype none
module test_up_down_pulse_counter;
	timeunit 1ns;
	timeprecision 1ns;
	import udpc_pkg::*;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, er;
	udpc_pins_s pins;
	int num_errors = 0;
	int checks = 0;
	always #20 pclk = ~pclk;
	udpc_top dut (.*);
	udpc_src src (.pclk(pclk), .pins(pins));
	////////////////////////////////
	task automatic results;
		$display("mismatches %0d of %0d checks", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Idle edge first, so psel is never assigned twice in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) begin
			num_errors++;
			results();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(what, exp, rd);
	endtask : rdc
	task automatic t_regs;
		apb(1'h1, 12'h008, 32'h5);
		for (int i = 0; i < 9; i++) begin
			rdc("reset value", 12'(4 * i), 32'h0);
		end
		rdc("unmapped data", 12'h100, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, er});
	endtask : t_regs
	// Row: control word, pins {inc, dec, dir, gate}, expected count of -1, 0 or 1
	// Last rows: increment on falling edges, decrement on the spare off code
	task automatic t_count;
		logic [7:0] ctl [19] = '{8'h91, 8'h91, 8'h91, 8'h91, 8'h51, 8'h51, 8'h51, 8'h51,
			8'h51, 8'h51, 8'h51, 8'h51, 8'h50, 8'h01, 8'h01, 8'h91, 8'he1, 8'he1, 8'he1};
		logic [3:0] pin [19] = '{4'hb, 4'h3, 4'h7, 4'h3, 4'hf, 4'h3, 4'h9, 4'h1,
			4'h5, 4'h0, 4'ha, 4'h3, 4'hb, 4'h3, 4'hf, 4'h3, 4'h7, 4'hb, 4'h3};
		logic [1:0] ex [19] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3,
			2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 2'h3, 2'h0};
		for (int i = 0; i < 19; i++) begin
			apb(1'h1, 12'h000, {24'h0, ctl[i]});
			src.step(pin[i][3], pin[i][2], pin[i][1], pin[i][0]);
			rdc("count", 12'h008, {{30{ex[i][1]}}, ex[i]});
		end
		// Compares at zero: steps -1 to 0 reach them, 0 to -1 undershoot them
		rdc("events", 12'h018, 32'hf);
		rdc("pins", 12'h020, 32'hc);
	endtask : t_count
	task automatic t_load;
		apb(1'h1, 12'h018, 32'h1f);
		apb(1'h1, 12'h004, 32'h9);
		apb(1'h1, 12'h000, 32'h13);
		rdc("strobe load", 12'h008, 32'h9);
		apb(1'h1, 12'h004, 32'h77);
		apb(1'h1, 12'h00c, 32'ha);
		apb(1'h1, 12'h014, 32'h9);
		apb(1'h1, 12'h000, 32'h51);
		src.step(1'h1, 1'h0, 1'h1, 1'h1);
		rdc("reached load", 12'h008, 32'h77);
		apb(1'h1, 12'h010, 32'h77);
		apb(1'h1, 12'h004, 32'h20);
		src.step(1'h0, 1'h1, 1'h1, 1'h1);
		rdc("undershot load", 12'h008, 32'h20);
		rdc("status", 12'h018, 32'h19);
		apb(1'h1, 12'h01c, 32'h1);
		repeat (3) @(posedge pclk);
		chk("irq set", 32'h1, {31'h0, irq});
		apb(1'h1, 12'h018, 32'h1);
		repeat (3) @(posedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rdc("status", 12'h018, 32'h18);
		apb(1'h1, 12'h01c, 32'h0);
	endtask : t_load
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_count();
		t_load();
		results();
	end
endmodule : test_up_down_pulse_counter
`default_nettype wire
